// ===== ccd_regs.svh
`ifndef CCD_REGS_SVH
`define CCD_REGS_SVH

// register byte offsets on the APB bus
`define OFS_INSN 12'h000
`define OFS_ACC 12'h004
`define OFS_STATUS 12'h008
`define OFS_PC 12'h00C
`define OFS_LATCH 12'h010
`define OFS_WATCHDOG 12'h014
`define OFS_STACK 12'h018
// file registers 0..127 sit at FILE_BASE + 4 * index
`define FILE_BASE_TOP 3'h1

// status field positions
`define ST_ZERO_BIT 0
`define ST_PWRDN_BIT 1
`define ST_TO_BIT 2
`define ST_BUSY_BIT 8

// reset values
`define ACC_RST 8'h00
`define PC_RST 13'h0000
`define LATCH_RST 8'h00
`define ZERO_RST 1'b0
`define FLAG_N_RST 1'b1

// instruction word patterns (14-bit)
`define OPW_WATCHDOG_CLEAR 14'h0064
`define OPH_CALL 3'h4
`define OPH_INVERT 6'h09
`define OPH_ZERO_REG 6'h01
`define OPH_MINUS_ONE 6'h03
`define OPH_MINUS_ONE_SKIP 6'h0B

// timing: one instruction cycle
`define CLK_PERIOD_NS 5
`define INSN_CYCLE_NS 20
`define INSN_CYCLE_CLKS ((`INSN_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== ccd_pkg.sv
package ccd_pkg;

    typedef enum logic [2:0] {
        other_op,
        watchdog_clear_op,
        call_op,
        invert_file_op,
        zero_file_op,
        minus_one_file_op,
        zero_accumulator_op,
        minus_one_skip_zero_op
    } op_kind_t;

    typedef struct packed {
        op_kind_t kind;
        logic dest;
        logic [6:0] faddr;
        logic [10:0] target;
    } decoded_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef enum logic [1:0] {
        idle_st,
        pending_st,
        second_st
    } exec_state_t;

endpackage

// ===== clear_call_decrement_exec.sv
`timescale 1ns/10ps
`include "ccd_regs.svh"
// Notes on behaviour
// - watchdog clear zeroes the watchdog counter and its prescaler
// - watchdog clear sets timeout and powerdown flags to one, nothing else
// - call pushes pc plus one onto the return stack first
// - call loads pc 10:0 from operand, pc 12:11 from upper latch 4:3
// - call takes two cycles, any operand 0..2047, no flag changes
// - invert writes the inverse of the file register, zero flag follows result
// - destination bit 0 goes to accumulator, 1 back to file register
// - file clear writes zero to register 0..127 and sets zero flag
// - decrement writes file minus one to destination, zero flag follows result
// - accumulator clear zeroes accumulator and sets zero flag
// - decrement-skip writes file minus one to destination, flags untouched
// - zero decrement-skip result discards the next instruction, two cycles
module clear_call_decrement_exec (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire ccd_pkg::apb_req_t apb_req,
    output ccd_pkg::apb_rsp_t apb_rsp,
    // status towards the rest of the core
    output logic timeout_flag_n,
    output logic powerdown_flag_n,
    output logic watchdog_clear_pulse
);
    import ccd_pkg::*;

    localparam int CYC_CLKS = `INSN_CYCLE_CLKS;
    localparam int DIV_W = (CYC_CLKS > 1) ? $clog2(CYC_CLKS) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYC_CLKS - 1);

    function automatic decoded_t decode(input logic [13:0] w);
        decoded_t d;
        d.dest = w[7];
        d.faddr = w[6:0];
        d.target = w[10:0];
        if (w == `OPW_WATCHDOG_CLEAR) begin
            d.kind = watchdog_clear_op;
        end else if (w[13:11] == `OPH_CALL) begin
            d.kind = call_op;
        end else if (w[13:8] == `OPH_INVERT) begin
            d.kind = invert_file_op;
        end else if (w[13:8] == `OPH_ZERO_REG) begin
            d.kind = w[7] ? zero_file_op : zero_accumulator_op;
        end else if (w[13:8] == `OPH_MINUS_ONE) begin
            d.kind = minus_one_file_op;
        end else if (w[13:8] == `OPH_MINUS_ONE_SKIP) begin
            d.kind = minus_one_skip_zero_op;
        end else begin
            d.kind = other_op;
        end
        return d;
    endfunction

    // state
    logic [DIV_W-1:0] div_q;
    exec_state_t state_q;
    logic [13:0] insn_q;
    logic [7:0] acc_q;
    logic zero_q;
    logic to_n_q;
    logic pwrdn_n_q;
    logic [12:0] pc_q;
    logic [7:0] latch_q;
    logic [7:0] wdog_cnt_q;
    logic [7:0] presc_q;
    logic [2:0] sp_q;
    logic [12:0] stack_mem [8];
    logic [7:0] file_mem [128];
    logic wclr_q;
    logic [31:0] prdata_q;
    logic loaded_q;

    // instruction cycle enable
    wire tick = (div_q == DIV_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
        end else begin
            div_q <= tick ? '0 : div_q + DIV_W'(1);
        end
    end

    // apb decode
    wire busy = (state_q != idle_st);
    wire [11:0] addr = apb_req.paddr;
    wire in_file = (addr[11:9] == `FILE_BASE_TOP);
    wire [6:0] apb_faddr = addr[8:2];
    wire hit_insn = (addr == `OFS_INSN);
    wire hit_acc = (addr == `OFS_ACC);
    wire hit_status = (addr == `OFS_STATUS);
    wire hit_pc = (addr == `OFS_PC);
    wire hit_latch = (addr == `OFS_LATCH);
    wire hit_wdog = (addr == `OFS_WATCHDOG);
    wire hit_stack = (addr == `OFS_STACK);
    wire mapped = in_file | hit_insn | hit_acc | hit_status | hit_pc | hit_latch
                | hit_wdog | hit_stack;
    // stalling every access while busy keeps software writes out of the
    // cycles in which an instruction updates the same state
    wire ready = !busy && loaded_q;
    wire apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && ready && mapped;
    wire [7:0] wb = apb_req.pwdata[7:0];

    // execution datapath
    wire decoded_t dec = decode(insn_q);
    wire [7:0] fval = file_mem[dec.faddr];
    wire [12:0] pc_plus1 = pc_q + 13'h0001;
    wire [12:0] pc_plus2 = pc_q + 13'h0002;
    wire [2:0] sp_top = sp_q - 3'h1;
    wire [12:0] stack_top = stack_mem[sp_top];
    wire [7:0] result = (dec.kind == invert_file_op) ? ~fval :
                        (dec.kind == zero_file_op) ? 8'h00 :
                        fval - 8'h01;
    wire res_zero = (result == 8'h00);
    wire exec = tick && (state_q == pending_st);
    wire is_dest_op = (dec.kind == invert_file_op) || (dec.kind == minus_one_file_op)
                    || (dec.kind == minus_one_skip_zero_op);
    wire exec_acc = exec && ((is_dest_op && !dec.dest)
                    || (dec.kind == zero_accumulator_op));
    wire exec_file = exec && ((is_dest_op && dec.dest)
                     || (dec.kind == zero_file_op));
    // the decrement-skip leaves the zero flag alone, call and watchdog clear too
    wire exec_zero = exec && ((dec.kind == invert_file_op)
                     || (dec.kind == minus_one_file_op)
                     || (dec.kind == zero_file_op)
                     || (dec.kind == zero_accumulator_op));
    wire exec_wclr = exec && (dec.kind == watchdog_clear_op);
    wire exec_call = exec && (dec.kind == call_op);
    wire skip_taken = (dec.kind == minus_one_skip_zero_op) && res_zero;
    wire two_cycle = (dec.kind == call_op) || skip_taken;

    // sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= idle_st;
        end else begin
            unique case (state_q)
                idle_st: if (apb_wr && hit_insn) state_q <= pending_st;
                pending_st: if (tick) state_q <= two_cycle ? second_st : idle_st;
                second_st: if (tick) state_q <= idle_st;
                // the fourth code of the state word is unused; fall back to idle
                default: state_q <= idle_st;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            insn_q <= 14'h0000;
        end else if (apb_wr && hit_insn) begin
            insn_q <= apb_req.pwdata[13:0];
        end
    end

    // accumulator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= `ACC_RST;
        end else if (exec_acc) begin
            acc_q <= (dec.kind == zero_accumulator_op) ? 8'h00 : result;
        end else if (apb_wr && hit_acc) begin
            acc_q <= wb;
        end
    end

    // status flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_q <= `ZERO_RST;
        end else if (exec_zero) begin
            zero_q <= res_zero || (dec.kind == zero_accumulator_op);
        end else if (apb_wr && hit_status) begin
            zero_q <= apb_req.pwdata[`ST_ZERO_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_n_q <= `FLAG_N_RST;
        end else if (exec_wclr) begin
            to_n_q <= 1'b1;
        end else if (apb_wr && hit_status) begin
            to_n_q <= apb_req.pwdata[`ST_TO_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwrdn_n_q <= `FLAG_N_RST;
        end else if (exec_wclr) begin
            pwrdn_n_q <= 1'b1;
        end else if (apb_wr && hit_status) begin
            pwrdn_n_q <= apb_req.pwdata[`ST_PWRDN_BIT];
        end
    end

    // program counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= `PC_RST;
        end else if (exec_call) begin
            pc_q <= {latch_q[4:3], dec.target};
        end else if (exec) begin
            pc_q <= skip_taken ? pc_plus2 : pc_plus1;
        end else if (apb_wr && hit_pc) begin
            pc_q <= apb_req.pwdata[12:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_q <= `LATCH_RST;
        end else if (apb_wr && hit_latch) begin
            latch_q <= wb;
        end
    end

    // return stack: eight entries, a ninth push overwrites the oldest
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_q <= 3'h0;
        end else if (exec_call) begin
            sp_q <= sp_q + 3'h1;
        end
    end

    always_ff @(posedge pclk) begin
        if (exec_call) begin
            stack_mem[sp_q] <= pc_plus1;
        end
    end

    // file registers hold data only, so they carry no reset
    always_ff @(posedge pclk) begin
        if (exec_file) begin
            file_mem[dec.faddr] <= result;
        end else if (apb_wr && in_file) begin
            file_mem[apb_faddr] <= wb;
        end
    end

    // watchdog prescaler advanced once per instruction cycle, the counter once per prescaler wrap;
    // a clear always lands on a tick, and the clear wins over the count
    wire presc_wrap = tick && (presc_q == 8'hFF);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= 8'h00;
        end else if (exec_wclr) begin
            presc_q <= 8'h00;
        end else if (tick) begin
            presc_q <= presc_q + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_cnt_q <= 8'h00;
        end else if (exec_wclr) begin
            wdog_cnt_q <= 8'h00;
        end else if (presc_wrap) begin
            wdog_cnt_q <= wdog_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wclr_q <= 1'b0;
        end else begin
            wclr_q <= exec_wclr;
        end
    end

    // read data is captured one cycle ahead so prdata comes from a flop;
    // the watchdog word can therefore be one cycle old when it is taken
    wire [31:0] status_word = {23'h0, busy, 5'h0, to_n_q, pwrdn_n_q, zero_q};
    wire [31:0] rd_mux = in_file ? {24'h0, file_mem[apb_faddr]} :
                         hit_insn ? {18'h0, insn_q} :
                         hit_acc ? {24'h0, acc_q} :
                         hit_status ? status_word :
                         hit_pc ? {19'h0, pc_q} :
                         hit_latch ? {24'h0, latch_q} :
                         hit_wdog ? {16'h0, presc_q, wdog_cnt_q} :
                         hit_stack ? {13'h0, sp_q, 3'h0, stack_top} :
                         32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else begin
            prdata_q <= rd_mux;
        end
    end

    // one idle selected cycle must pass before ready, so prdata is fresh
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loaded_q <= 1'b0;
        end else begin
            loaded_q <= apb_req.psel && !busy;
        end
    end

    assign apb_rsp.prdata = prdata_q;
    assign apb_rsp.pready = ready;
    assign apb_rsp.pslverr = ready && apb_req.psel && apb_req.penable && !mapped;
    assign timeout_flag_n = to_n_q;
    assign powerdown_flag_n = pwrdn_n_q;
    assign watchdog_clear_pulse = wclr_q;

endmodule // clear_call_decrement_exec

// ===== ccd_props.sv
`timescale 1ns/10ps
`include "ccd_regs.svh"
module ccd_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bus
    input wire ccd_pkg::apb_req_t apb_req,
    input wire ccd_pkg::apb_rsp_t apb_rsp,
    // status
    input wire logic timeout_flag_n,
    input wire logic powerdown_flag_n,
    input wire logic watchdog_clear_pulse
);
    import ccd_pkg::*;
    wire logic acc_w = apb_req.psel && apb_req.penable;
    wire logic tk = acc_w && apb_rsp.pready;
    wire logic wr = tk && apb_req.pwrite;
    wire logic okd = apb_req.paddr < 12'h01C || apb_req.paddr[11:9] == 3'h1;
    wire logic unm = apb_req.paddr[1:0] == 2'h0 && !okd;
    logic [3:0] wait_q;
    logic [3:0] since_q;
    // both counters saturate so a hang still reads as a large value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wait_q <= 4'h0;
        else if (!(acc_w && !apb_rsp.pready)) wait_q <= 4'h0;
        else if (wait_q != 4'hF) wait_q <= wait_q + 4'h1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) since_q <= 4'hF;
        else if (wr && apb_req.paddr == `OFS_INSN) since_q <= 4'h0;
        else if (since_q != 4'hF) since_q <= since_q + 4'h1;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    pulse_width_a: assert property (watchdog_clear_pulse |=> !watchdog_clear_pulse)
        else $error("clear pulse too wide");
    pulse_cause_a: assert property (watchdog_clear_pulse |-> since_q <= 4'hA)
        else $error("clear pulse without instruction");
    pulse_flags_a: assert property (watchdog_clear_pulse |-> timeout_flag_n && powerdown_flag_n)
        else $error("flags not set by clear");
    flag_rise_a: assert property (($rose(timeout_flag_n) || $rose(powerdown_flag_n))
        && !$past(wr) |-> ##[0:1] watchdog_clear_pulse) else $error("flag rose without cause");
    flag_fall_a: assert property (($fell(timeout_flag_n) || $fell(powerdown_flag_n))
        |-> $past(wr)) else $error("flag fell without write");
    err_ready_a: assert property (acc_w && apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("error without ready");
    unmapped_err_a: assert property (tk && unm |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
        else $error("unmapped access not flagged");
    mapped_ok_a: assert property (tk && okd |-> !apb_rsp.pslverr)
        else $error("mapped access flagged");
    wait_bound_a: assert property (acc_w |-> wait_q <= 4'hE)
        else $error("access stalled too long");
    cover property (since_q == 4'h0);
    cover property (watchdog_clear_pulse);
    cover property (tk && unm);
    cover property (wait_q == 4'h6);
endmodule // ccd_props

bind clear_call_decrement_exec ccd_props ccd_props_inst (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .timeout_flag_n(timeout_flag_n),
    .powerdown_flag_n(powerdown_flag_n), .watchdog_clear_pulse(watchdog_clear_pulse));

// ===== tb_clear_call_decrement_exec.sv
`timescale 1ns/10ps
`include "ccd_regs.svh"
module tb_clear_call_decrement_exec;
    import ccd_pkg::*;
    logic pclk;
    logic presetn;
    apb_req_t req;
    apb_rsp_t rsp;
    logic to_n, pwrdn_n, wpulse, er, tw_e, z_e = 0, to_e = 1, pwrdn_e = 1;
    int failures = 0, n_checks = 0, np = 0, np_e = 0, wt = 0;
    logic [7:0] acc_e = 8'h00, lat_e, mem_e [128];
    logic [12:0] pc_e = 13'h0000, top_e;
    logic [2:0] sp_e = 3'h0;
    logic [31:0] seed = 32'd37, rd, v;
    logic [13:0] ins;
    logic [13:0] ops [8] = '{14'h0064, 14'h2000, 14'h0900, 14'h0180, 14'h0100, 14'h0300,
        14'h0B00, 14'h0000};
    logic [13:0] msk [8] = '{14'h0, 14'h07FF, 14'h00FF, 14'h007F, 14'h007F, 14'h00FF,
        14'h00FF, 14'h0};

    clear_call_decrement_exec clear_call_decrement_exec_inst (.pclk(pclk), .presetn(presetn),
        .apb_req(req), .apb_rsp(rsp), .timeout_flag_n(to_n), .powerdown_flag_n(pwrdn_n),
        .watchdog_clear_pulse(wpulse));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) if (wpulse === 1'b1) np++;

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // expected effect of one instruction word on the bench's copy of the state
    function void model(input logic [13:0] n);
        logic [7:0] r;
        r = (n[13:8] == 6'h09) ? ~mem_e[n[6:0]] : mem_e[n[6:0]] - 8'h01;
        // a call, or a decrement-skip that reaches zero, takes two instruction cycles
        tw_e = (n[13:11] == 3'h4) || (n[13:8] == 6'h0B && r == 8'h00);
        pc_e = pc_e + 13'h0001;
        if (n == 14'h0064) begin
            to_e = 1'b1;
            pwrdn_e = 1'b1;
            np_e++;
        end else if (n[13:11] == 3'h4) begin
            top_e = pc_e;
            sp_e++;
            pc_e = {lat_e[4:3], n[10:0]};
        end else if (n[13:7] == 7'h03) begin
            mem_e[n[6:0]] = 8'h00;
            z_e = 1'b1;
        end else if (n[13:7] == 7'h02) begin
            acc_e = 8'h00;
            z_e = 1'b1;
        end else if (n[13:8] inside {6'h09, 6'h03, 6'h0B}) begin
            if (n[7]) mem_e[n[6:0]] = r;
            else acc_e = r;
            if (n[13:8] != 6'h0B) z_e = (r == 8'h00);
            else if (r == 8'h00) pc_e++;
        end
    endfunction

    task chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    task test_done;
        if (failures == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // holds the request until ready is seen at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 100);
        if (k >= 100) failures++;
        wt = k;
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rd, x);
    endtask

    initial begin
        presetn = 1'b0;
        req = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`OFS_ACC, 32'h0);
        rdc(`OFS_STATUS, 32'h6);
        rdc(`OFS_PC, 32'h0);
        for (int i = 0; i < 64; i++) begin
            v = rnd();
            ins = ops[i % 8] | (v[13:0] & msk[i % 8]);
            if (i == 1) ins = 14'h27FF;
            if (i == 9) ins = 14'h2000;
            v = rnd();
            if (i % 3 == 0) v[7:0] = 8'h01;
            if (i % 5 == 0) v[7:0] = 8'h00;
            apb(1'b1, {3'h1, ins[6:0], 2'h0}, v);
            mem_e[ins[6:0]] = v[7:0];
            v = rnd();
            apb(1'b1, `OFS_LATCH, v);
            lat_e = v[7:0];
            if (i % 8 == 0) begin
                apb(1'b1, `OFS_STATUS, 32'h0);
                {z_e, to_e, pwrdn_e} = 3'h0;
                #1 chk({to_n, pwrdn_n}, 32'h0);
            end
            apb(1'b1, `OFS_INSN, {18'h0, ins});
            model(ins);
            rdc(`OFS_ACC, {24'h0, acc_e});
            // the access after the instruction waits at most 4 cycles unless it ran two
            chk(wt > 4, tw_e);
            rdc(`OFS_STATUS, {29'h0, to_e, pwrdn_e, z_e});
            rdc(`OFS_PC, {19'h0, pc_e});
            rdc({3'h1, ins[6:0], 2'h0}, {24'h0, mem_e[ins[6:0]]});
            if (i % 8 == 1) rdc(`OFS_STACK, {13'h0, sp_e, 3'h0, top_e});
            if (i % 8 == 0) begin
                apb(1'b0, `OFS_WATCHDOG, 32'h0);
                chk(rd & 32'hFFFF_F8FF, 32'h0);
            end
            chk(np, np_e);
            chk({to_n, pwrdn_n}, {to_e, pwrdn_e});
        end
        rdc(12'h01C, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, 12'h400, rnd());
        chk(er, 1'b1);
        test_done;
    end

    initial begin
        #200000;
        failures++;
        test_done;
    end
endmodule // tb_clear_call_decrement_exec
